// >>> ibc_consts.vh
`ifndef IBC_CONSTS_VH
`define IBC_CONSTS_VH
// Function
// - Idle bus write launches start, address.
// - Busy write requests stop sequence.
// - Busy follows bus start and stop.
// - Interrupt clears pending; clock held low.
// - Word end clears; buffer access sets.
// - Clock released one low period later.
// - Address or general call clears pending.
// - Pending written one sets, zero ignored.
// - Mode field value 10 selects bus.
// - Data mismatch at clock rise loses.
// - Loser releases its data pin.
// - Loser drops master, finishes word clocks.
// - Buffer access or control two write clears.
// - Address match sets addressed flag.
// - General call flag on zero byte.
// - Last bit sampled every clock rise.
// - Falling edge ending the word (bits, plus ack bit in acknowledge mode) raises interrupt.
// - Direction updates transmit bit on ack.
// - Acknowledge clock only in acknowledge mode.
// - Word length forced zero at start.
// - Master bit cleared on stop, loss.
// - Transmit bit follows slave direction.
////////////////////////////////////////////////////////////////
`define IBC_CLK_NS     5
`define IBC_CLOCK_LOW_PERIOD_NS    4700
`define IBC_THIGH_NS   4000
`define IBC_CLOCK_LOW_PERIOD_CYC   ((`IBC_CLOCK_LOW_PERIOD_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_THIGH_CYC  ((`IBC_THIGH_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_CNT_W      10
`define IBC_MODE_BUS   2'h2
`define IBC_CR2_MST    7
`define IBC_CR2_TRX    6
`define IBC_CR2_BB     5
`define IBC_CR2_PIN    4
`define IBC_CR2_MD_HI  3
`define IBC_CR2_MD_LO  2
`define IBC_CR1_BC_HI  7
`define IBC_CR1_BC_LO  5
`define IBC_CR1_ACK    4
`define IBC_BC_RST     3'h0
`define IBC_WORD_FULL  4'h8
`define IBC_GCALL      8'h00
`define IBC_MSB        3'h7
`endif

// >>> ibc_sync.v
`timescale 1ns/1ps
`include "ibc_consts.vh"
module ibc_sync #(
  parameter W = 2
) (
  input  wire         i_ref_clk,
  input  wire         i_srst,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // Idle bus lines reset high
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      meta   <= {W{1'b1}};
      o_sync <= {W{1'b1}};
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // ibc_sync

// >>> ibc_scl_gen.v
`timescale 1ns/1ps
`include "ibc_consts.vh"
module ibc_scl_gen #(
  parameter LOW_CYC  = `IBC_CLOCK_LOW_PERIOD_CYC,
  parameter HIGH_CYC = `IBC_THIGH_CYC
) (
  input  wire i_ref_clk,
  input  wire i_srst,
  input  wire i_run,
  input  wire i_scl_bus,
  output wire o_scl_low
);
  localparam G_LOW  = 2'h1;
  localparam G_HIGH = 2'h2;
  localparam [31:0]           LOW_M1    = LOW_CYC - 1;
  localparam [31:0]           HIGH_M1   = HIGH_CYC - 1;
  localparam [`IBC_CNT_W-1:0] LOW_LAST  = LOW_M1[`IBC_CNT_W-1:0];
  localparam [`IBC_CNT_W-1:0] HIGH_LAST = HIGH_M1[`IBC_CNT_W-1:0];

  reg [1:0]            state;
  reg [`IBC_CNT_W-1:0] cnt;

  assign o_scl_low = i_run & state[0];

  always @(posedge i_ref_clk) begin
    if (i_srst || !i_run) begin
      state <= G_LOW;
      cnt   <= {`IBC_CNT_W{1'b0}};
    end else begin
      case (state)
        G_LOW: begin
          if (cnt == LOW_LAST) begin
            state <= G_HIGH;
            cnt   <= {`IBC_CNT_W{1'b0}};
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        G_HIGH: begin
          // Another master pulled low early: resync
          if (i_scl_bus) begin
            if (cnt == HIGH_LAST) begin
              state <= G_LOW;
              cnt   <= {`IBC_CNT_W{1'b0}};
            end else begin
              cnt <= cnt + 1'b1;
            end
          end else if (cnt != {`IBC_CNT_W{1'b0}}) begin
            state <= G_LOW;
            cnt   <= {`IBC_CNT_W{1'b0}};
          end
        end
        default: begin
          state <= G_LOW;
          cnt   <= {`IBC_CNT_W{1'b0}};
        end
      endcase
    end
  end
endmodule // ibc_scl_gen

// >>> ibc_ctrl.v
`timescale 1ns/1ps
`include "ibc_consts.vh"
module ibc_ctrl #(
  parameter LOW_CYC  = `IBC_CLOCK_LOW_PERIOD_CYC,
  parameter HIGH_CYC = `IBC_THIGH_CYC
) (
  input  wire       i_ref_clk,
  input  wire       i_srst,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_scl_o,
  output reg        o_scl_oe_n,
  output wire       o_sda_o,
  output reg        o_sda_oe_n,
  input  wire       i_cr1_wr,
  input  wire [7:0] i_cr1_wdata,
  input  wire       i_cr2_wr,
  input  wire [7:0] i_cr2_wdata,
  input  wire       i_dbuf_wr,
  input  wire [7:0] i_dbuf_wdata,
  input  wire       i_dbuf_rd,
  input  wire [6:0] i_own_addr,
  input  wire       i_address_recognition_off,
  output reg  [7:0] o_data_buffer,
  output wire [7:0] o_status_reg,
  output wire [2:0] o_word_bit_count,
  output wire       o_ack_mode,
  output wire [1:0] o_interface_mode_field,
  output reg        o_serial_bus_irq
);
  localparam S_IDLE  = 5'h01;
  localparam S_START = 5'h02;
  localparam S_XFER  = 5'h04;
  localparam S_STLO  = 5'h08;
  localparam S_STHI  = 5'h10;
  localparam [31:0]           LOW_M1    = LOW_CYC - 1;
  localparam [31:0]           HIGH_M1   = HIGH_CYC - 1;
  localparam [`IBC_CNT_W-1:0] LOW_LAST  = LOW_M1[`IBC_CNT_W-1:0];
  localparam [`IBC_CNT_W-1:0] HIGH_LAST = HIGH_M1[`IBC_CNT_W-1:0];

  function [3:0] ibc_len;
    input [2:0] bc;
    begin
      ibc_len = (bc == `IBC_BC_RST) ? `IBC_WORD_FULL : {1'b0, bc};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus sampling
  wire [1:0] bus_s;
  wire       scl_s = bus_s[1];
  wire       sda_s = bus_s[0];
  reg        scl_q;
  reg        sda_q;

  ibc_sync #(
    .W (2)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   ({i_scl, i_sda}),
    .o_sync    (bus_s)
  );

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  ////////////////////////////////////////////////////////////////
  // Register state
  reg       master_select;
  reg       transmit_select;
  reg       bb;
  reg       pin;
  reg       al;
  reg       addressed_as_slave_flag;
  reg       ad0;
  reg       last_received_bit;
  reg [1:0] mode;
  reg [2:0] bc;
  reg       ack;
  reg [7:0] txr;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg       pre;
  reg       first;
  reg       sel;
  reg       skip;
  reg       sda_low;
  reg       stop_pend;
  reg [4:0] state;
  reg [`IBC_CNT_W-1:0] cnt;
  reg [`IBC_CNT_W-1:0] rel_cnt;
  reg       pin_rel;
  wire      gen_low;

  wire mode_ok  = (mode == `IBC_MODE_BUS);
  wire buf_acc  = i_dbuf_wr | i_dbuf_rd;
  wire [3:0] len   = ibc_len(bc);
  wire [3:0] total = len + {3'h0, ack};
  wire [3:0] nbit  = bitcnt + 4'h1;
  wire end_w    = (nbit == total);
  wire gcall    = (shreg == `IBC_GCALL);
  wire match    = (shreg[7:1] == i_own_addr) | gcall;
  wire active   = bb & ~skip & mode_ok;

  wire start_req = i_cr2_wr & mode_ok & ~bb & i_cr2_wdata[`IBC_CR2_MST]
                 & i_cr2_wdata[`IBC_CR2_TRX] & i_cr2_wdata[`IBC_CR2_BB];
  wire stop_req  = i_cr2_wr & mode_ok & bb & i_cr2_wdata[`IBC_CR2_MST]
                 & i_cr2_wdata[`IBC_CR2_TRX] & i_cr2_wdata[`IBC_CR2_PIN]
                 & ~i_cr2_wdata[`IBC_CR2_BB];
  wire word_done = active & scl_fall & ~pre & end_w;
  wire lose      = active & scl_rise & ~pre & master_select & state[2]
                 & (bitcnt < len) & ~sda_low & ~sda_s;

  assign o_status_reg           = {master_select, transmit_select, bb, pin, al, addressed_as_slave_flag, ad0, last_received_bit};
  assign o_word_bit_count       = bc;
  assign o_ack_mode             = ack;
  assign o_interface_mode_field = mode;
  assign o_scl_o                = 1'b0;
  assign o_sda_o                = 1'b0;

  ////////////////////////////////////////////////////////////////
  // Software access and bus events
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      master_select <= 1'b0;
      transmit_select <= 1'b0;
      bb <= 1'b0;
      pin <= 1'b1;
      al <= 1'b0;
      addressed_as_slave_flag <= 1'b0;
      ad0 <= 1'b0;
      last_received_bit <= 1'b0;
      mode <= 2'h0;
      bc <= `IBC_BC_RST;
      ack <= 1'b0;
      txr <= 8'h00;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      pre <= 1'b0;
      first <= 1'b0;
      sel <= 1'b0;
      skip <= 1'b0;
      sda_low <= 1'b0;
      o_data_buffer <= 8'h00;
      o_serial_bus_irq <= 1'b0;
    end else begin
      o_serial_bus_irq <= 1'b0;
      if (i_cr1_wr) begin
        bc  <= i_cr1_wdata[`IBC_CR1_BC_HI:`IBC_CR1_BC_LO];
        ack <= i_cr1_wdata[`IBC_CR1_ACK];
      end
      if (i_cr2_wr) begin
        master_select  <= i_cr2_wdata[`IBC_CR2_MST];
        transmit_select  <= i_cr2_wdata[`IBC_CR2_TRX];
        mode <= i_cr2_wdata[`IBC_CR2_MD_HI:`IBC_CR2_MD_LO];
        if (i_cr2_wdata[`IBC_CR2_PIN])
          pin <= 1'b1;
        al <= 1'b0;
      end
      if (buf_acc) begin
        pin <= 1'b1;
        al  <= 1'b0;
        addressed_as_slave_flag <= 1'b0;
      end
      if (i_dbuf_wr) begin
        txr <= i_dbuf_wdata;
        // First bit of a new word drives at once
        if (transmit_select & ~al & bb & ~pre)
          sda_low <= ~i_dbuf_wdata[`IBC_MSB];
      end
      if (scl_rise)
        last_received_bit <= sda_s;
      if (active & scl_rise & ~pre & (bitcnt < len))
        shreg <= {shreg[6:0], sda_s};
      if (active & scl_fall) begin
        if (pre) begin
          pre <= 1'b0;
          sda_low <= transmit_select & ~txr[`IBC_MSB];
        end else if (end_w) begin
          bitcnt <= 4'h0;
          first <= 1'b0;
          sda_low <= 1'b0;
          o_data_buffer <= shreg;
          if (master_select) begin
            pin <= 1'b0;
            o_serial_bus_irq <= 1'b1;
            if (first & ~last_received_bit)
              transmit_select <= ~shreg[0];
          end else if (first & ~i_address_recognition_off) begin
            if (match) begin
              pin <= 1'b0;
              o_serial_bus_irq <= 1'b1;
              addressed_as_slave_flag <= 1'b1;
              ad0 <= gcall;
              transmit_select <= shreg[0];
              sel <= 1'b1;
            end else if (al) begin
              pin <= 1'b0;
              o_serial_bus_irq <= 1'b1;
            end else begin
              skip <= 1'b1;
            end
          end else if (first) begin
            addressed_as_slave_flag <= 1'b1;
            sel <= 1'b1;
            pin <= 1'b0;
            o_serial_bus_irq <= 1'b1;
          end else if (sel | al) begin
            pin <= 1'b0;
            o_serial_bus_irq <= 1'b1;
          end
        end else begin
          bitcnt <= nbit;
          if (nbit < len)
            sda_low <= transmit_select & ~al & ~txr[`IBC_MSB - nbit[2:0]];
          else
            sda_low <= ack & ~transmit_select & (master_select | sel | (first & match
                       & ~i_address_recognition_off) | (first
                       & i_address_recognition_off));
        end
      end
      if (lose) begin
        al <= 1'b1;
        master_select <= 1'b0;
        transmit_select <= 1'b0;
        sda_low <= 1'b0;
      end
      if (start_det) begin
        bb <= 1'b1;
        bc <= `IBC_BC_RST;
        bitcnt <= 4'h0;
        pre <= 1'b1;
        first <= 1'b1;
        ad0 <= 1'b0;
        sel <= 1'b0;
        skip <= 1'b0;
        sda_low <= 1'b0;
      end
      if (stop_det) begin
        bb <= 1'b0;
        master_select <= 1'b0;
        transmit_select <= 1'b0;
        ad0 <= 1'b0;
        sel <= 1'b0;
        skip <= 1'b0;
        pre <= 1'b0;
        sda_low <= 1'b0;
      end
      if (!mode_ok) begin
        sda_low <= 1'b0;
        bb <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Clock release after pending set
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rel_cnt <= {`IBC_CNT_W{1'b0}};
      pin_rel <= 1'b1;
    end else if (!pin) begin
      rel_cnt <= {`IBC_CNT_W{1'b0}};
      pin_rel <= 1'b0;
    end else if (!pin_rel) begin
      if (rel_cnt == LOW_LAST)
        pin_rel <= 1'b1;
      else
        rel_cnt <= rel_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Master start, clocking and stop
  always @(posedge i_ref_clk) begin
    if (i_srst || !mode_ok) begin
      state <= S_IDLE;
      cnt <= {`IBC_CNT_W{1'b0}};
      stop_pend <= 1'b0;
    end else begin
      if (stop_req)
        stop_pend <= 1'b1;
      case (state)
        S_IDLE: begin
          cnt <= {`IBC_CNT_W{1'b0}};
          stop_pend <= 1'b0;
          if (start_req)
            state <= S_START;
        end
        S_START: begin
          if (cnt == HIGH_LAST) begin
            state <= S_XFER;
            cnt <= {`IBC_CNT_W{1'b0}};
          end else if (scl_s) begin
            cnt <= cnt + 1'b1;
          end
        end
        S_XFER: begin
          if (word_done & ~master_select)
            state <= S_IDLE;
          else if ((stop_pend | stop_req) & ~scl_s & ~gen_low) begin
            state <= S_STLO;
            cnt <= {`IBC_CNT_W{1'b0}};
          end else if ((stop_pend | stop_req) & ~scl_s & ~pin_rel) begin
            state <= S_STLO;
            cnt <= {`IBC_CNT_W{1'b0}};
          end
        end
        S_STLO: begin
          if (cnt == LOW_LAST) begin
            state <= S_STHI;
            cnt <= {`IBC_CNT_W{1'b0}};
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_STHI: begin
          // Waits while others stretch the clock
          if (scl_s) begin
            if (cnt == HIGH_LAST)
              state <= S_IDLE;
            else
              cnt <= cnt + 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ibc_scl_gen #(
    .LOW_CYC  (LOW_CYC),
    .HIGH_CYC (HIGH_CYC)
  ) u_gen (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_run     (state[2] & mode_ok),
    .i_scl_bus (scl_s),
    .o_scl_low (gen_low)
  );

  ////////////////////////////////////////////////////////////////
  // Pin drivers
  wire drv_sda = mode_ok & (state[1] | state[3] | state[4] | sda_low);
  wire drv_scl = mode_ok & (gen_low | state[3] | (bb & (~pin | ~pin_rel)));

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_sda_oe_n <= 1'b1;
      o_scl_oe_n <= 1'b1;
    end else begin
      o_sda_oe_n <= ~drv_sda;
      o_scl_oe_n <= ~drv_scl;
    end
  end
endmodule // ibc_ctrl

// >>> ibc_ctrl_sva.sv
`timescale 1ns/1ps
module ibc_ctrl_sva #(
  parameter LOW_CYC  = 940,
  parameter HIGH_CYC = 800
) (
  input wire       i_ref_clk,
  input wire       i_srst,
  input wire       i_scl,
  input wire       i_sda,
  input wire       o_scl_oe_n,
  input wire       o_sda_oe_n,
  input wire       i_cr2_wr,
  input wire [7:0] i_cr2_wdata,
  input wire       i_dbuf_wr,
  input wire       i_dbuf_rd,
  input wire [7:0] o_status_reg,
  input wire [2:0] o_word_bit_count,
  input wire [1:0] o_interface_mode_field,
  input wire       o_serial_bus_irq
);
  int rel_wait;
  reg pin_q;
  // Cycles the clock stays held since pending rose
  always @(posedge i_ref_clk) begin
    pin_q <= o_status_reg[4];
    if (i_srst || !o_status_reg[4] || o_scl_oe_n)
      rel_wait <= 0;
    else if (!pin_q || rel_wait != 0)
      rel_wait <= rel_wait + 1;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_irq_clears_pin: assert property (
    o_serial_bus_irq |-> ##[0:1] !o_status_reg[4]) else $error("pending not cleared");
  a_irq_holds_scl: assert property (
    o_serial_bus_irq |-> ##[0:2] (!o_scl_oe_n)[*4]) else $error("clock not held");
  a_pin_set_one: assert property (
    i_cr2_wr && i_cr2_wdata[4] |=> o_status_reg[4] != o_serial_bus_irq)
    else $error("pending not set");
  a_buf_sets_pin: assert property (
    i_dbuf_wr || i_dbuf_rd |=> (o_status_reg[4] != o_serial_bus_irq)
    && (o_status_reg[3:2] == 2'h0 || o_serial_bus_irq))
    else $error("buffer access side effects wrong");
  a_lost_drops: assert property (
    $rose(o_status_reg[3]) |-> ##[0:2] (o_status_reg[7:6] == 2'h0 && o_sda_oe_n))
    else $error("loser kept master or data");
  a_scl_release: assert property (
    rel_wait != 0 && rel_wait < LOW_CYC |=> !o_scl_oe_n) else $error("clock released early");
  a_scl_let_go: assert property (
    rel_wait <= LOW_CYC + 4) else $error("clock held too long");
  a_start_seen: assert property (
    $fell(i_sda) && i_scl && o_interface_mode_field == 2'h2 |-> ##[1:6]
    (o_status_reg[5] && o_word_bit_count == 3'h0 && !o_status_reg[1]))
    else $error("start not tracked");
  a_stop_seen: assert property (
    $rose(i_sda) && i_scl && o_interface_mode_field == 2'h2 |-> ##[1:6]
    (o_status_reg[7:5] == 3'h0 && !o_status_reg[1])) else $error("stop not tracked");
endmodule // ibc_ctrl_sva

bind ibc_ctrl ibc_ctrl_sva #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_sva (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
  .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n), .i_cr2_wr(i_cr2_wr),
  .i_cr2_wdata(i_cr2_wdata), .i_dbuf_wr(i_dbuf_wr), .i_dbuf_rd(i_dbuf_rd),
  .o_status_reg(o_status_reg), .o_word_bit_count(o_word_bit_count),
  .o_interface_mode_field(o_interface_mode_field), .o_serial_bus_irq(o_serial_bus_irq));

// >>> ibc_slave_model.sv
`timescale 1ns/1ps
module ibc_slave_model #(
  parameter [6:0] ADDR = 7'h2A
) (
  input  wire i_scl,
  input  wire i_sda,
  output reg  o_sda_oe_n
);
  reg [7:0] sh;
  integer   n;
  initial begin
    o_sda_oe_n = 1'b1;
    sh = 8'h00;
    n = 10;
  end
  // Start: listen for a new address
  always @(negedge i_sda) if (i_scl) n = 0;
  always @(posedge i_scl) if (n < 8) begin
    sh = {sh[6:0], i_sda};
    n = n + 1;
  end
  // Acknowledge own address, then release
  always @(negedge i_scl) begin
    if (n == 9) o_sda_oe_n <= #20 1'b1;
    if (n == 8 && sh[7:1] == ADDR) o_sda_oe_n <= #20 1'b0;
    if (n == 8 || n == 9) n = n + 1;
  end
endmodule // ibc_slave_model

// >>> i2c_bus_controller_bench.sv
`timescale 1ns/1ps
module i2c_bus_controller_bench;
  reg        i_ref_clk;
  reg        i_srst, address_recognition_off;
  reg        cr1_wr, cr2_wr, dbuf_wr, dbuf_rd;
  reg  [7:0] wd;
  reg        tb_scl_n, tb_sda_n;
  wire       scl_o, sda_o, scl_oe_n, sda_oe_n, slv_sda_n, irq, ack_mode;
  wire [7:0] status, dbuf;
  wire [2:0] wbc;
  wire [1:0] mode;
  integer    n_errors, checked, cyc;
  // Open-drain lines with pull-ups
  wire       scl = (scl_oe_n | scl_o) & tb_scl_n;
  wire       sda = (sda_oe_n | sda_o) & slv_sda_n & tb_sda_n;

  ibc_ctrl #(.LOW_CYC(8), .HIGH_CYC(8)) DUT (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
    .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
    .i_cr1_wr(cr1_wr), .i_cr1_wdata(wd), .i_cr2_wr(cr2_wr), .i_cr2_wdata(wd),
    .i_dbuf_wr(dbuf_wr), .i_dbuf_wdata(wd), .i_dbuf_rd(dbuf_rd), .i_own_addr(7'h3C),
    .i_address_recognition_off(address_recognition_off), .o_data_buffer(dbuf), .o_status_reg(status),
    .o_word_bit_count(wbc), .o_ack_mode(ack_mode), .o_interface_mode_field(mode),
    .o_serial_bus_irq(irq));
  ibc_slave_model #(.ADDR(7'h2A)) u_slave (.i_scl(scl), .i_sda(sda), .o_sda_oe_n(slv_sda_n));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("Checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // Kind 1 control one, 2 control two, 3 buffer write, 4 buffer read
  task wr(input integer r, input [7:0] d);
    begin
      @(posedge i_ref_clk) #1;
      cr1_wr = (r == 1);
      cr2_wr = (r == 2);
      dbuf_wr = (r == 3);
      dbuf_rd = (r == 4);
      wd = d;
      @(posedge i_ref_clk) #1;
      {cr1_wr, cr2_wr, dbuf_wr, dbuf_rd} = 4'h0;
      @(posedge i_ref_clk) #1;
    end
  endtask
  // Kind 0 interrupt, 1 bus free, 2 clock line high, 3 bus busy
  task wait_on(input integer w);
    integer k;
    begin
      k = 0;
      while (k < 4000 && ((w == 0) ? irq : (w == 1) ? !status[5] : (w == 2) ? scl
             : status[5]) !== 1'b1) begin
        @(posedge i_ref_clk) #1;
        k = k + 1;
      end
      if (k == 4000) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: wait ran out", $time);
      end
      repeat (2) @(posedge i_ref_clk);
      #1;
    end
  endtask

  // Another master wins the address word by holding data low
  task arb_run(input ro, input [7:0] exp);
    begin
      address_recognition_off = ro;
      wr(3, 8'hA0);
      wr(2, 8'hF8);
      wait_on(3);
      tb_sda_n = 1'b0;
      wait_on(0);
      tb_sda_n = 1'b1;
      chk({status[7:1], 1'b0}, exp);
      chk(dbuf, 8'h00);
      wr(4, 8'h00);
      chk({3'h0, status[4:2], 2'h0}, 8'h10);
      wait_on(2);
      #24 tb_scl_n = 1'b0;
      #24 tb_sda_n = 1'b0;
      #24 tb_scl_n = 1'b1;
      wait_on(2);
      #24 tb_sda_n = 1'b1;
      wait_on(1);
      chk(status, 8'h10);
    end
  endtask

  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: run too long", $time);
      end_sim;
    end
  end

  initial begin
    {i_srst, cr1_wr, cr2_wr, dbuf_wr, dbuf_rd, tb_scl_n, tb_sda_n} = 7'h43;
    wd = 8'h00;
    address_recognition_off = 1'b0;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge i_ref_clk);
    #1 i_srst = 1'b0;
    chk(status, 8'h10);
    chk({4'h0, scl_oe_n, sda_oe_n, mode}, 8'h0C);
    $display("Test reset done");
    wr(1, 8'h70);
    wr(2, 8'h18);
    chk({wbc, ack_mode, 2'h0, mode}, 8'h72);
    wr(2, 8'h08);
    chk(status, 8'h10);
    $display("Test init done");
    wr(3, {7'h2A, 1'b1});
    wr(2, 8'hF8);
    wait_on(0);
    chk(status, 8'hA0);
    chk(dbuf, 8'h55);
    chk({5'h0, wbc}, 8'h00);
    wr(2, 8'hD8);
    wait_on(1);
    chk(status, 8'h10);
    $display("Test acked address done");
    wr(3, {7'h55, 1'b1});
    wr(2, 8'hF8);
    wait_on(0);
    chk(status, 8'hE1);
    chk(dbuf, 8'hAB);
    wr(2, 8'hD8);
    wait_on(1);
    chk(status, 8'h10);
    $display("Test refused address done");
    arb_run(1'b0, 8'h2E);
    $display("Test arbitration done");
    arb_run(1'b1, 8'h2C);
    $display("Test recognition off done");
    wr(2, 8'h10);
    chk({4'h0, scl_oe_n, sda_oe_n, mode}, 8'h0C);
    $display("Test port mode done");
    end_sim;
  end
endmodule // i2c_bus_controller_bench
